/* inc/qcsi_baud_if.sv */
// Interface: settings from the register file to the baud generator,
// and the generated serial clock back.
`timescale 1ns/1ps
`default_nettype none
interface qcsi_baud_if;
    logic [2:0] prescaler_select;
    logic [2:0] divider_select;
    logic sclk;
    logic sclk_tick;
    logic running;
    modport ctrl(output prescaler_select, output divider_select,
                 input sclk, input sclk_tick, input running);
    modport gen(input prescaler_select, input divider_select,
                output sclk, output sclk_tick, output running);
endinterface
`default_nettype wire

/* inc/qcsi_pkg.sv */
// Package: register map, field layout and constants of the serial
// clock and chip-select / length control block.
// Assumes an AXI4-Lite master with 32-bit data and word-aligned access.
package qcsi_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_CLOCK_CTRL = 4'h0;
    localparam logic [3:0] OFF_CS_LENGTH = 4'h4;
    localparam logic [3:0] OFF_ENABLE = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hc;
    localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;
    localparam logic [7:0] CS_LENGTH_RESET = 8'h00;
    localparam int PRESC_LSB = 5;
    localparam int PRESC_W = 3;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 3;
    localparam int POL_LSB = 4;
    localparam int POL_W = 4;
    localparam int LEN_LSB = 0;
    localparam int LEN_W = 4;
    localparam logic [2:0] PRESC_SLAVE = 3'h7;
    localparam logic [2:0] DIV_STOP = 3'h0;
    localparam logic [3:0] LEN_SIXTEEN = 4'h0;
    localparam logic [4:0] LEN_SIXTEEN_BITS = 5'h10;
    localparam logic [4:0] LEN_BASE_BITS = 5'h08;
    localparam int ENA_TX_BIT = 0;
    localparam int ENA_RX_BIT = 1;
    localparam int ENA_CS_BIT = 2;
    localparam int PRESC_CNT_W = 6;
    localparam int DIV_CNT_W = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* logic/qcsi_baud_gen.sv */
// Baud generator: prescaler by 2^K, then divider by 2N, toggling sclk.
// Assumes settings only change while transmit and receive are disabled.
`timescale 1ns/1ps
`default_nettype none
module qcsi_baud_gen (
    input wire logic i_ref_clk, // Module clock
    input wire logic i_resetn, // Async reset, active low
    input wire logic i_ce, // Clock enable
    qcsi_baud_if.gen bif // Settings and clock out
);
    typedef struct packed {
        logic [qcsi_pkg::PRESC_CNT_W-1:0] pcnt;
        logic [qcsi_pkg::DIV_CNT_W-1:0] dcnt;
        logic sclk;
        logic tick;
        logic run;
    } state_s;
    state_s st, next_st;
    logic [qcsi_pkg::PRESC_CNT_W-1:0] pmask;
    logic master;
    logic prs_out;
    always_comb begin
        pmask = qcsi_pkg::PRESC_CNT_W'((7'h01 << bif.prescaler_select) - 7'h01);
        master = (bif.prescaler_select != qcsi_pkg::PRESC_SLAVE) &&
                 (bif.divider_select != qcsi_pkg::DIV_STOP);
        prs_out = ((st.pcnt & pmask) == pmask);
        next_st = st;
        next_st.tick = 1'b0;
        next_st.run = master;
        if (!master) begin
            next_st.pcnt = '0;
            next_st.dcnt = '0;
            next_st.sclk = 1'b0;
        end else begin
            next_st.pcnt = (st.pcnt & pmask) == pmask ? '0 : st.pcnt + 1'b1;
            if (prs_out) begin
                // Half period is N prescaler outputs: full period 2N * 2^K
                if (st.dcnt + 1'b1 >= bif.divider_select) begin
                    next_st.dcnt = '0;
                    next_st.sclk = ~st.sclk;
                    next_st.tick = 1'b1;
                end else begin
                    next_st.dcnt = st.dcnt + 1'b1;
                end
            end
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end
    assign bif.sclk = st.sclk;
    assign bif.sclk_tick = st.tick;
    assign bif.running = st.run;

    // Count module clocks between sclk toggles; the first toggle after a
    // settings change is skipped, the counters start out of phase there
    logic [9:0] gap;
    logic [5:0] cfg_q;
    logic settled;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gap <= '0;
            cfg_q <= '0;
            settled <= 1'b0;
        end else if (i_ce) begin
            gap <= (st.tick || !st.run) ? 10'h001 : gap + 10'h001;
            cfg_q <= {bif.prescaler_select, bif.divider_select};
            if (cfg_q != {bif.prescaler_select, bif.divider_select}) begin
                settled <= 1'b0;
            end else if (st.tick) begin
                settled <= 1'b1;
            end
        end
    end
    a_half_period: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && st.tick && st.run && settled && $stable(bif.prescaler_select) &&
         $stable(bif.divider_select) && gap > 10'h001) |->
        (gap == 10'((11'h001 << bif.prescaler_select) * bif.divider_select)))
        else $error("sclk half period wrong");
    a_stop_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && bif.divider_select == qcsi_pkg::DIV_STOP) |=> !st.tick)
        else $error("baud generator runs while stopped");
    a_slave_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && bif.prescaler_select == qcsi_pkg::PRESC_SLAVE) |=> !st.sclk)
        else $error("sclk driven in slave mode");
    c_fast_clock: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        st.tick && bif.prescaler_select == 3'h0 && bif.divider_select == 3'h1);
    c_slow_clock: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        st.tick && bif.prescaler_select == 3'h6 && bif.divider_select == 3'h7);
endmodule // qcsi_baud_gen
`default_nettype wire

/* logic/qcsi_cs_length_baud.sv */
// Register file over AXI4-Lite, chip-select polarity and word length,
// and the baud generator instance.
// Assumes software obeys the write restrictions while enabled.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module qcsi_cs_length_baud #(
    parameter int NUM_CS = 4
) (
    input wire logic i_ref_clk, // Module clock 40 MHz
    input wire logic i_resetn, // Async reset, active low
    input wire logic i_ce, // Clock enable, freezes all state
    input wire logic i_cs_select, // Chip-select request per queue logic
    input wire logic [qcsi_pkg::ADDR_W-1:0] i_awaddr, // Write address
    input wire logic i_awvalid, // Write address valid
    output logic o_awready, // Write address ready
    input wire logic [31:0] i_wdata, // Write data
    input wire logic [3:0] i_wstrb, // Write strobes
    input wire logic i_wvalid, // Write data valid
    output logic o_wready, // Write data ready
    output logic [1:0] o_bresp, // Write response
    output logic o_bvalid, // Write response valid
    input wire logic i_bready, // Write response ready
    input wire logic [qcsi_pkg::ADDR_W-1:0] i_araddr, // Read address
    input wire logic i_arvalid, // Read address valid
    output logic o_arready, // Read address ready
    output logic [31:0] o_rdata, // Read data
    output logic [1:0] o_rresp, // Read response
    output logic o_rvalid, // Read data valid
    input wire logic i_rready, // Read data ready
    output logic [NUM_CS-1:0] o_chip_select_out, // Chip-select pins
    output logic o_sclk, // Serial clock out
    output logic o_sclk_oe, // Serial clock drive enable, master mode
    output logic [4:0] o_word_length, // Word length in bits
    output logic o_transmit_enable, // Transmit enable to shifter
    output logic o_receive_enable // Receive enable to shifter
);
    typedef struct packed {
        logic [7:0] clock_phase_control;
        logic [7:0] cs_length_control;
        logic transmit_enable_bit;
        logic receive_enable_bit;
        logic cs_force;
        logic aw_got;
        logic w_got;
        logic [qcsi_pkg::ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [NUM_CS-1:0] cs_pins;
        logic sclk;
        logic sclk_oe;
        logic [4:0] word_len;
        logic sticky_bad_len;
    } state_s;
    state_s st, next_st;
    qcsi_baud_if bif();
    logic [3:0] len_code;
    logic [3:0] pol;
    logic wr_fire;
    logic [7:0] wr_byte;
    logic locked;

    qcsi_baud_gen u_baud (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .bif(bif)
    );
    assign bif.prescaler_select =
        st.clock_phase_control[qcsi_pkg::PRESC_LSB +: qcsi_pkg::PRESC_W];
    assign bif.divider_select =
        st.clock_phase_control[qcsi_pkg::DIV_LSB +: qcsi_pkg::DIV_W];

    always_comb begin
        next_st = st;
        wr_fire = 1'b0;
        wr_byte = st.wdata[7:0];
        locked = st.transmit_enable_bit || st.receive_enable_bit;
        if (i_awvalid && !st.aw_got && !st.bvalid) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = i_awaddr;
        end
        if (i_wvalid && !st.w_got && !st.bvalid) begin
            next_st.w_got = 1'b1;
            next_st.wdata = i_wdata;
            next_st.wstrb = i_wstrb;
        end
        if (st.aw_got && st.w_got) begin
            wr_fire = 1'b1;
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = qcsi_pkg::RESP_OKAY;
            unique case (st.awaddr)
                qcsi_pkg::OFF_CLOCK_CTRL: begin
                    if (st.wstrb[0] && !locked) begin
                        next_st.clock_phase_control = wr_byte;
                    end
                end
                qcsi_pkg::OFF_CS_LENGTH: begin
                    if (st.wstrb[0] && !locked) begin
                        next_st.cs_length_control = wr_byte;
                    end
                end
                qcsi_pkg::OFF_ENABLE: begin
                    if (st.wstrb[0]) begin
                        next_st.transmit_enable_bit = wr_byte[qcsi_pkg::ENA_TX_BIT];
                        next_st.receive_enable_bit = wr_byte[qcsi_pkg::ENA_RX_BIT];
                        next_st.cs_force = wr_byte[qcsi_pkg::ENA_CS_BIT];
                    end
                end
                qcsi_pkg::OFF_STATUS: begin
                    if (st.wstrb[0] && wr_byte[0]) begin
                        next_st.sticky_bad_len = 1'b0;
                    end
                end
                default: begin
                    next_st.bresp = qcsi_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st.bvalid && i_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (i_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = qcsi_pkg::RESP_OKAY;
            unique case (i_araddr)
                qcsi_pkg::OFF_CLOCK_CTRL: next_st.rdata = {24'h000000, st.clock_phase_control};
                qcsi_pkg::OFF_CS_LENGTH: next_st.rdata = {24'h000000, st.cs_length_control};
                qcsi_pkg::OFF_ENABLE: next_st.rdata = {29'h00000000, st.cs_force,
                    st.receive_enable_bit, st.transmit_enable_bit};
                qcsi_pkg::OFF_STATUS: next_st.rdata = {24'h000000, st.word_len,
                    bif.running, bif.sclk, st.sticky_bad_len};
                default: begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = qcsi_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && i_rready) begin
            next_st.rvalid = 1'b0;
        end
        len_code = next_st.cs_length_control[qcsi_pkg::LEN_LSB +: qcsi_pkg::LEN_W];
        pol = next_st.cs_length_control[qcsi_pkg::POL_LSB +: qcsi_pkg::POL_W];
        if (len_code == qcsi_pkg::LEN_SIXTEEN) begin
            next_st.word_len = qcsi_pkg::LEN_SIXTEEN_BITS;
        end else if (len_code[3]) begin
            next_st.word_len = qcsi_pkg::LEN_BASE_BITS + {2'h0, len_code[2:0]};
        end else begin
            // Prohibited code: keep 16 bits, flag it in status
            next_st.word_len = qcsi_pkg::LEN_SIXTEEN_BITS;
            next_st.sticky_bad_len = 1'b1;
        end
        // Pins follow the polarity register value at once
        for (int i = 0; i < NUM_CS; i++) begin
            next_st.cs_pins[i] = (i < qcsi_pkg::POL_W) ?
                (pol[i % qcsi_pkg::POL_W] ~^ (st.cs_force && i_cs_select)) : 1'b1;
        end
        next_st.sclk = bif.sclk;
        next_st.sclk_oe = (bif.prescaler_select != qcsi_pkg::PRESC_SLAVE);
    end
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
            st.clock_phase_control <= qcsi_pkg::CLOCK_CTRL_RESET;
            st.cs_length_control <= qcsi_pkg::CS_LENGTH_RESET;
            st.cs_pins <= '1;
            st.word_len <= qcsi_pkg::LEN_SIXTEEN_BITS;
            st.sclk_oe <= 1'b1;
        end else if (i_ce) begin
            st <= next_st;
        end
    end
    assign o_awready = i_ce && !st.aw_got && !st.bvalid;
    assign o_wready = i_ce && !st.w_got && !st.bvalid;
    assign o_arready = i_ce && !st.rvalid;
    assign o_bvalid = st.bvalid;
    assign o_bresp = st.bresp;
    assign o_rvalid = st.rvalid;
    assign o_rresp = st.rresp;
    assign o_rdata = st.rdata;
    assign o_chip_select_out = st.cs_pins;
    assign o_sclk = st.sclk;
    assign o_sclk_oe = st.sclk_oe;
    assign o_word_length = st.word_len;
    assign o_transmit_enable = st.transmit_enable_bit;
    assign o_receive_enable = st.receive_enable_bit;

    a_cs_follow: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && !st.cs_force) |=> (o_chip_select_out[0] == ~$past(pol[0])))
        else $error("chip select idle level wrong");
    a_cs_quick: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && wr_fire && st.awaddr == qcsi_pkg::OFF_CS_LENGTH && st.wstrb[0] &&
         !locked && !st.cs_force) |=> (o_chip_select_out[0] == ~st.cs_length_control[4]))
        else $error("chip select not updated on write");
    a_len_sixteen: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (st.cs_length_control[qcsi_pkg::LEN_LSB +: qcsi_pkg::LEN_W] == qcsi_pkg::LEN_SIXTEEN) |->
        (o_word_length == qcsi_pkg::LEN_SIXTEEN_BITS))
        else $error("code zero not 16 bits");
    a_len_range: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (st.cs_length_control[3] && $stable(st.cs_length_control) && $past(i_ce)) |->
        (o_word_length == {1'b0, 1'b1, st.cs_length_control[2:0]}))
        else $error("word length mismatch");
    a_reg_lock: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (locked && $past(locked)) |-> $stable(st.cs_length_control))
        else $error("control written while enabled");
    a_reg_width: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (st.rvalid && $past(st.rvalid == 1'b0) && $past(i_araddr) == qcsi_pkg::OFF_CS_LENGTH)
        |-> (o_rdata[31:8] == 24'h000000))
        else $error("upper bits not zero");
    a_slave_oe: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && bif.prescaler_select == qcsi_pkg::PRESC_SLAVE) |=> !o_sclk_oe)
        else $error("sclk driven in slave mode");
    a_wr_resp: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && wr_fire && !st.bvalid) |=> o_bvalid)
        else $error("missing write response");
    c_write_cs: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        wr_fire && st.awaddr == qcsi_pkg::OFF_CS_LENGTH);
    c_len_nine: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_word_length == 5'h09);
    c_locked_write: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        wr_fire && locked);
endmodule // qcsi_cs_length_baud
`default_nettype wire

/* tb/qcsi_periph_model.sv */
// Serial peripheral model: watches the serial clock it is fed and
// reports the length of the last half period in module clocks.
// Assumes the serial clock is sampled on the module clock.
`timescale 1ns/1ps
`default_nettype none
module qcsi_periph_model (
    input wire logic i_clk, // Module clock
    input wire logic i_resetn, // Async reset, active low
    input wire logic i_sclk, // Serial clock from the block
    output int o_half, // Last half period seen
    output int o_toggles // Serial clock edges seen
);
    logic last;
    int cnt;
    // Edge spacing is what the peripheral relies on for timing
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            last <= 1'b0;
            cnt <= 0;
            o_half <= 0;
            o_toggles <= 0;
        end else begin
            last <= i_sclk;
            if (i_sclk !== last) begin
                o_half <= cnt;
                o_toggles <= o_toggles + 1;
                cnt <= 1;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule // qcsi_periph_model
`default_nettype wire

/* tb/tb_queued_csi_cs_length_baud.sv */
// Testbench: drives the register file over AXI4-Lite and checks pins,
// word length and serial clock rate against expected values.
// Assumes a single 40 MHz module clock and the peripheral model.
`timescale 1ns/1ps
`default_nettype none
module tb_queued_csi_cs_length_baud;
    logic i_ref_clk, i_resetn, i_cs_select, i_ce;
    logic [3:0] i_awaddr, i_araddr, i_wstrb, o_chip_select_out;
    logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [31:0] i_wdata, o_rdata, d;
    logic [1:0] o_bresp, o_rresp, r;
    logic o_sclk, o_sclk_oe, o_transmit_enable, o_receive_enable;
    logic [4:0] o_word_length;
    int errors, n_tests, cyc, half, toggles, t0;
    int ks[3] = '{0, 2, 6};
    int ns[3] = '{1, 3, 7};
    logic [3:0] pols[2] = '{4'ha, 4'h5};

    qcsi_cs_length_baud uut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(i_ce),
        .i_cs_select(i_cs_select), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
        .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_chip_select_out(o_chip_select_out), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe),
        .o_word_length(o_word_length), .o_transmit_enable(o_transmit_enable),
        .o_receive_enable(o_receive_enable));
    qcsi_periph_model peer (.i_clk(i_ref_clk), .i_resetn(i_resetn), .i_sclk(o_sclk),
        .o_half(half), .o_toggles(toggles));

    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 50000) begin
            errors++;
            $display("ERROR t=%0t run hung", $time);
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        bit aw, w, aw_ok, w_ok;
        aw = 0;
        w = 0;
        i_awaddr <= a;
        i_wdata <= v;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        // Handshake seen between edges, so the design's own update at the
        // edge cannot race the check
        while (!(aw && w)) begin
            @(negedge i_ref_clk);
            aw_ok = !aw && o_awready === 1'b1;
            w_ok = !w && o_wready === 1'b1;
            @(posedge i_ref_clk);
            if (aw_ok) begin
                aw = 1;
                i_awvalid <= 1'b0;
            end
            if (w_ok) begin
                w = 1;
                i_wvalid <= 1'b0;
            end
        end
        i_bready <= 1'b1;
        do @(negedge i_ref_clk); while (o_bvalid !== 1'b1);
        rs = o_bresp;
        @(posedge i_ref_clk);
        i_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        do @(negedge i_ref_clk); while (o_arready !== 1'b1);
        @(posedge i_ref_clk);
        i_arvalid <= 1'b0;
        i_rready <= 1'b1;
        do @(negedge i_ref_clk); while (o_rvalid !== 1'b1);
        v = o_rdata;
        rs = o_rresp;
        @(posedge i_ref_clk);
        i_rready <= 1'b0;
    endtask

    initial begin
        i_resetn = 1'b0;
        {i_cs_select, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        i_awaddr = '0;
        i_araddr = '0;
        i_wdata = '0;
        i_wstrb = 4'hf;
        i_ce = 1'b1;
        repeat (3) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(posedge i_ref_clk);
        axi_read(qcsi_pkg::OFF_CS_LENGTH, d, r);
        chk(d, 32'h0, "reset value");
        chk({28'h0, o_chip_select_out}, 32'hf, "cs idle");
        chk({27'h0, o_word_length}, 32'h10, "reset length");
        $display("test reset done");
        axi_write(qcsi_pkg::OFF_ENABLE, 32'h4, r);
        foreach (pols[i]) begin
            axi_write(qcsi_pkg::OFF_CS_LENGTH, {24'h0, pols[i], 4'h8}, r);
            @(posedge i_ref_clk);
            chk({28'h0, o_chip_select_out}, {28'h0, ~pols[i]}, "cs inactive");
            i_cs_select <= 1'b1;
            repeat (3) @(posedge i_ref_clk);
            chk({28'h0, o_chip_select_out}, {28'h0, pols[i]}, "cs active");
            i_cs_select <= 1'b0;
        end
        $display("test polarity done");
        axi_write(qcsi_pkg::OFF_ENABLE, 32'h0, r);
        for (int c = 8; c < 17; c++) begin
            axi_write(qcsi_pkg::OFF_CS_LENGTH, {28'h0, 4'(c)}, r);
            @(posedge i_ref_clk);
            chk({27'h0, o_word_length}, 32'(c), "length");
            chk({28'h0, o_chip_select_out}, 32'hf, "cs idle level");
            axi_read(qcsi_pkg::OFF_CS_LENGTH, d, r);
            chk(d, {28'h0, 4'(c)}, "length readback");
        end
        axi_read(qcsi_pkg::OFF_STATUS, d, r);
        chk(d, {24'h0, qcsi_pkg::LEN_SIXTEEN_BITS, 3'h0}, "status length");
        $display("test length done");
        foreach (ks[i]) begin
            axi_write(qcsi_pkg::OFF_CLOCK_CTRL, {24'h0, 3'(ks[i]), 2'b00, 3'(ns[i])}, r);
            axi_write(qcsi_pkg::OFF_ENABLE, 32'h1, r);
            t0 = toggles;
            while (toggles < t0 + 4) @(posedge i_ref_clk);
            chk(32'(half), 32'((1 << ks[i]) * ns[i]), "half period");
            chk({31'h0, o_transmit_enable}, 32'h1, "tx enable");
            if (i == 0) begin
                // Clock enable low must freeze the serial clock
                i_ce <= 1'b0;
                @(posedge i_ref_clk);
                @(negedge i_ref_clk);
                t0 = toggles;
                repeat (8) @(negedge i_ref_clk);
                chk(32'(toggles), 32'(t0), "frozen clock");
                @(posedge i_ref_clk);
                i_ce <= 1'b1;
            end
            axi_write(qcsi_pkg::OFF_ENABLE, 32'h0, r);
        end
        $display("test baud done");
        axi_write(qcsi_pkg::OFF_CLOCK_CTRL, 32'h20, r);
        axi_write(qcsi_pkg::OFF_ENABLE, 32'h3, r);
        chk({31'h0, o_receive_enable}, 32'h1, "rx enable");
        repeat (20) @(posedge i_ref_clk);
        chk({31'h0, o_sclk}, 32'h0, "stopped clock");
        axi_write(qcsi_pkg::OFF_CS_LENGTH, 32'hff, r);
        chk({30'h0, r}, {30'h0, qcsi_pkg::RESP_OKAY}, "locked resp");
        axi_read(qcsi_pkg::OFF_CS_LENGTH, d, r);
        chk(d, 32'h0, "locked write");
        axi_write(qcsi_pkg::OFF_ENABLE, 32'h0, r);
        $display("test lock done");
        axi_write(qcsi_pkg::OFF_CLOCK_CTRL, 32'he1, r);
        @(posedge i_ref_clk);
        chk({31'h0, o_sclk_oe}, 32'h0, "slave mode");
        axi_write(qcsi_pkg::OFF_CLOCK_CTRL, 32'h01, r);
        @(posedge i_ref_clk);
        chk({31'h0, o_sclk_oe}, 32'h1, "master mode");
        axi_read(4'h2, d, r);
        chk({30'h0, r}, {30'h0, qcsi_pkg::RESP_SLVERR}, "unmapped read");
        axi_write(4'h2, 32'h0, r);
        chk({30'h0, r}, {30'h0, qcsi_pkg::RESP_SLVERR}, "unmapped write");
        $display("test mode and map done");
        wrap_up();
    end
endmodule // tb_queued_csi_cs_length_baud
`default_nettype wire
